// ---- design/eeprom_data_access_ctrl.sv ----
// EEPROM data access controller: registers, read path, write path
//
// Contract
// R1: Address register six bits, top reads zero
// R2: Control top nibble zero, bits reset zero
// R3: Program-permit low refuses every write
// R4: Program-go starts write, cleared when done
// R5: Program-go without prior permit starts nothing
// R6: Fetch-permit low refuses every read
// R7: Fetch-go starts read, cleared when done
// R8: Fetch-go without prior permit starts nothing
// R9: Software never sets go bits together
// R10: Data register full eight bits read/write
// R11: Read result held until next operation
// R12: Software reads: permit, address, go, poll; the core model's fetch waits three cycles instead of polling
// R13: Software writes: permit then go next
// R14: Software masks global interrupts around write
// R15: Async write timer, completion synchronised back
// R16: Reset clears permit and bank select
// R17: Write end sets EEPROM and multi flags
// R18: Vector only with all enables, stack room
// R19: Service clears multi flag, software EEPROM flag
// R20: Software keeps permit clear when idle; the core model's fetch leaves the fetch permit set
// R21: Array holds sixty-four bytes from zero
// R22: Control register at 40H bank one
// R23: Read finishes in fixed short cycle count
// R24: Write undisturbed until timer reports done
`timescale 1ns/1ps
module eeprom_data_access_ctrl #(
   parameter int DEPTH      = eeprom_ctrl_pkg::ARRAY_DEPTH,
   parameter int PROG_TICKS = eeprom_ctrl_pkg::PROG_TICKS
) (
   input  wire logic       MCLK_I,
   input  wire logic       RST_B_I,
   input  wire logic       CLK_EN_I,
   input  wire logic       TMR_CLK_I,
   input  wire logic       SFR_WR_I,
   input  wire logic       SFR_RD_I,
   input  wire logic [7:0] SFR_ADDR_I,
   input  wire logic [7:0] SFR_WDATA_I,
   input  wire logic       BANK_WR_I,
   input  wire logic       BANK_WDATA_I,
   input  wire logic       GLOBAL_IRQ_ENABLE_I,
   input  wire logic       MULTI_IRQ_ENABLE_I,
   input  wire logic       STACK_FULL_I,
   input  wire logic       MULTI_SERVICE_I,
   input  wire logic       EEPROM_IRQ_ENABLE_WR_I,
   input  wire logic       EEPROM_IRQ_ENABLE_I,
   input  wire logic       EEPROM_IRQ_FLAG_CLR_I,
   output logic [7:0]      SFR_RDATA_O,
   output logic            BANK_SELECT_O,
   output logic            EEPROM_IRQ_FLAG_O,
   output logic            MULTI_IRQ_FLAG_O,
   output logic            IRQ_VECTOR_O,
   output logic            BUSY_O
);
   ////////////////////////////////////////////////////////////////////
   eeprom_ctrl_pkg::sfr_req_s  req;
   eeprom_ctrl_pkg::ctrl_state_e state_q;
   logic [7:0]  mem [DEPTH];
   logic [5:0]  addr_q;
   logic [7:0]  data_q;
   logic        prog_permit_q;
   logic        prog_go_q;
   logic        fetch_permit_q;
   logic        fetch_go_q;
   logic        irq_en_q;
   logic [1:0]  rd_cnt_q;
   logic        start_tgl_q;
   logic        done_tgl;
   logic [2:0]  done_sync_q;
   logic        done_seen_q;
   logic        prog_done;
   logic        hit_addr;
   logic        hit_data;
   logic        hit_ctrl;
   logic [7:0]  ctrl_wr;
   logic        start_read;
   logic        start_prog;
   logic        read_end;
   logic        prog_end;
   logic [7:0]  rd_mux;

   assign req = '{wr: SFR_WR_I, rd: SFR_RD_I, bank: BANK_SELECT_O,
                  addr: SFR_ADDR_I, wdata: SFR_WDATA_I};

   // Address decode; control only visible with bank one selected
   assign hit_addr = req.addr == eeprom_ctrl_pkg::ADDR_REG_OFS;
   assign hit_data = req.addr == eeprom_ctrl_pkg::DATA_REG_OFS;
   assign hit_ctrl = (req.addr == eeprom_ctrl_pkg::CONTROL_REG_OFS)
                     && (req.bank == eeprom_ctrl_pkg::CONTROL_BANK); // R22
   assign ctrl_wr  = req.wdata;

   // Go bits honoured only if permit already set before this write
   assign start_read = CLK_EN_I && req.wr && hit_ctrl
                       && ctrl_wr[eeprom_ctrl_pkg::FETCH_GO_BIT]
                       && fetch_permit_q && !fetch_go_q
                       && state_q == eeprom_ctrl_pkg::ST_IDLE; // R6 R8
   assign start_prog = CLK_EN_I && req.wr && hit_ctrl
                       && ctrl_wr[eeprom_ctrl_pkg::PROG_GO_BIT]
                       && prog_permit_q && !prog_go_q
                       && state_q == eeprom_ctrl_pkg::ST_IDLE; // R3 R5

   // Cycle end strobes; one place decides when a cycle is over
   assign read_end = state_q == eeprom_ctrl_pkg::ST_READ
                     && rd_cnt_q == eeprom_ctrl_pkg::READ_CYCLES - 2'h1;
   assign prog_end = state_q == eeprom_ctrl_pkg::ST_PROG && prog_done;

   ////////////////////////////////////////////////////////////////////
   // Bank select, reset to bank zero
   // Bank zero hides the control register from stray writes
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         BANK_SELECT_O <= eeprom_ctrl_pkg::BANK_RST; // R16
      end else if (CLK_EN_I && BANK_WR_I) begin
         BANK_SELECT_O <= BANK_WDATA_I;
      end
   end

   // Address register, no reset value
   always_ff @(posedge MCLK_I) begin
      if (CLK_EN_I && req.wr && hit_addr) begin
         addr_q <= req.wdata[eeprom_ctrl_pkg::ADDR_W-1:0]; // R1
      end
   end

   // Permit bits, plain read/write
   // A go bit only counts if its permit came from an earlier write
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         prog_permit_q  <= eeprom_ctrl_pkg::CONTROL_RST[3]; // R2 R16
         fetch_permit_q <= eeprom_ctrl_pkg::CONTROL_RST[1]; // R2
      end else if (CLK_EN_I && req.wr && hit_ctrl) begin
         prog_permit_q  <= ctrl_wr[eeprom_ctrl_pkg::PROG_PERMIT_BIT];
         fetch_permit_q <= ctrl_wr[eeprom_ctrl_pkg::FETCH_PERMIT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Cycle sequencer; software cannot cancel a running cycle
   // Both go bits in one write: the write wins, the read is dropped
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         state_q    <= eeprom_ctrl_pkg::ST_IDLE;
         fetch_go_q <= 1'b0;
         prog_go_q  <= 1'b0;
         rd_cnt_q   <= 2'h0;
      end else if (CLK_EN_I) begin
         case (state_q)
            eeprom_ctrl_pkg::ST_IDLE: begin
               if (start_prog) begin
                  state_q   <= eeprom_ctrl_pkg::ST_PROG;
                  prog_go_q <= 1'b1; // R4
               end else if (start_read) begin
                  state_q    <= eeprom_ctrl_pkg::ST_READ;
                  fetch_go_q <= 1'b1; // R7
                  rd_cnt_q   <= 2'h0;
               end
            end
            eeprom_ctrl_pkg::ST_READ: begin
               if (read_end) begin
                  state_q    <= eeprom_ctrl_pkg::ST_IDLE;
                  fetch_go_q <= 1'b0; // R7 R23
               end else begin
                  rd_cnt_q <= rd_cnt_q + 2'h1;
               end
            end
            eeprom_ctrl_pkg::ST_PROG: begin
               if (prog_done) begin
                  state_q   <= eeprom_ctrl_pkg::ST_IDLE;
                  prog_go_q <= 1'b0; // R4 R24
               end
            end
            default: begin
               state_q <= eeprom_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data register: software writes, read result lands at read end
   // A read end wins over a software write in the same cycle
   always_ff @(posedge MCLK_I) begin
      if (CLK_EN_I) begin
         if (read_end) begin
            data_q <= mem[addr_q]; // R11 R21
         end else if (req.wr && hit_data
                      && state_q != eeprom_ctrl_pkg::ST_PROG) begin
            data_q <= req.wdata; // R10 R24
         end
      end
   end

   // Array written once programming starts; data frozen, address register still writable
   // Writing at launch keeps the model simple; the flag still waits
   always_ff @(posedge MCLK_I) begin
      if (CLK_EN_I && start_prog) begin
         mem[addr_q] <= data_q; // R21
      end
   end

   // Launch toggle to the asynchronous write timer
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         start_tgl_q <= 1'b0;
      end else if (start_prog) begin
         start_tgl_q <= ~start_tgl_q; // R15
      end
   end

   // Timer has no reset of its own: it runs on the free oscillator.
   // A stray done toggle after power-on is harmless, as it only ends
   // a cycle when it matches the launch toggle of a running write.
   eeprom_prog_timer #(
      .TICKS       (PROG_TICKS)
   ) u_timer (
      .tmr_clk_i   (TMR_CLK_I),
      .start_tgl_i (start_tgl_q),
      .done_tgl_o  (done_tgl)
   );

   // Done toggle back through three flops; counts when last two agree
   // A toggle, not a pulse, so no slow timer edge can slip past
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         done_sync_q <= 3'h0;
         done_seen_q <= 1'b0;
      end else if (CLK_EN_I) begin
         done_sync_q <= {done_sync_q[1:0], done_tgl};
         if (done_sync_q[2] == done_sync_q[1]) begin
            done_seen_q <= done_sync_q[2];
         end
      end
   end
   // Compare against launch toggle so stale edges never end a cycle
   assign prog_done = (done_sync_q[2] == done_sync_q[1])
                      && (done_sync_q[2] != done_seen_q)
                      && (done_sync_q[2] == start_tgl_q); // R15

   ////////////////////////////////////////////////////////////////////
   // EEPROM interrupt enable
   // Loaded by its own strobe; it does not live in the control register
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         irq_en_q <= 1'b0;
      end else if (CLK_EN_I && EEPROM_IRQ_ENABLE_WR_I) begin
         irq_en_q <= EEPROM_IRQ_ENABLE_I;
      end
   end

   // Request flags; write-end set beats any clear in the same cycle
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         EEPROM_IRQ_FLAG_O <= 1'b0;
         MULTI_IRQ_FLAG_O  <= 1'b0;
      end else if (CLK_EN_I) begin
         if (prog_end) begin
            EEPROM_IRQ_FLAG_O <= 1'b1; // R17
            MULTI_IRQ_FLAG_O  <= 1'b1; // R17
         end else begin
            if (EEPROM_IRQ_FLAG_CLR_I) begin
               EEPROM_IRQ_FLAG_O <= 1'b0; // R19
            end
            if (MULTI_SERVICE_I) begin
               MULTI_IRQ_FLAG_O <= 1'b0; // R19
            end
         end
      end
   end

   // Vector request needs every enable and stack room
   // Dropped in the service cycle so one request is not taken twice
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         IRQ_VECTOR_O <= 1'b0;
      end else if (CLK_EN_I) begin
         IRQ_VECTOR_O <= EEPROM_IRQ_FLAG_O && MULTI_IRQ_FLAG_O
                         && irq_en_q && MULTI_IRQ_ENABLE_I
                         && GLOBAL_IRQ_ENABLE_I && !STACK_FULL_I
                         && !MULTI_SERVICE_I; // R18
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux; unmapped or hidden addresses give zero
   always_comb begin
      rd_mux = 8'h00;
      if (hit_addr) begin
         rd_mux = {2'h0, addr_q}; // R1
      end else if (hit_data) begin
         rd_mux = data_q; // R10
      end else if (hit_ctrl) begin
         rd_mux = {4'h0, prog_permit_q, prog_go_q,
                   fetch_permit_q, fetch_go_q}; // R2
      end
   end

   // Registered read data; zero in any clock-enabled cycle without a read, held while CLK_EN_I is low
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         SFR_RDATA_O <= 8'h00;
         BUSY_O      <= 1'b0;
      end else if (CLK_EN_I) begin
         BUSY_O      <= state_q != eeprom_ctrl_pkg::ST_IDLE;
         SFR_RDATA_O <= req.rd ? rd_mux : 8'h00;
      end
   end
endmodule

// ---- design/eeprom_ctrl_pkg.sv ----
// Shared constants and types for the EEPROM data access controller
package eeprom_ctrl_pkg;
   // Special function register addresses
   localparam logic [7:0] ADDR_REG_OFS    = 8'h00;
   localparam logic [7:0] DATA_REG_OFS    = 8'h01;
   localparam logic [7:0] CONTROL_REG_OFS = 8'h40;
   // Bank holding each register
   localparam logic       ADDR_BANK       = 1'h0;
   localparam logic       CONTROL_BANK    = 1'h1;
   // Control register field positions
   localparam int         FETCH_GO_BIT    = 0;
   localparam int         FETCH_PERMIT_BIT = 1;
   localparam int         PROG_GO_BIT     = 2;
   localparam int         PROG_PERMIT_BIT = 3;
   // Reset values
   localparam logic [3:0] CONTROL_RST     = 4'h0;
   localparam logic       BANK_RST        = 1'h0;
   // Array geometry
   localparam int         ARRAY_DEPTH     = 64;
   localparam int         ADDR_W          = 6;
   // Read cycle length in system clocks
   localparam logic [1:0] READ_CYCLES     = 2'h2;
   // Write timer: programming time and timer tick
   localparam int         PROG_TIME_US    = 4000;
   localparam int         TIMER_TICK_NS   = 1000;
   localparam int         PROG_TICKS      = PROG_TIME_US * 1000 / TIMER_TICK_NS;

   // Register bus request from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_PROG = 2'b10
   } ctrl_state_e;
endpackage

// ---- design/eeprom_prog_timer.sv ----
// Write-cycle timer running on its own free oscillator
`timescale 1ns/1ps
module eeprom_prog_timer #(
   parameter int TICKS = eeprom_ctrl_pkg::PROG_TICKS
) (
   input  wire logic tmr_clk_i,
   input  wire logic start_tgl_i,
   output logic      done_tgl_o
);
   logic [2:0]  start_sync_q;
   logic        start_seen_q;
   logic        busy_q;
   logic [15:0] count_q;

   // Start toggle crosses in from the system clock
   always_ff @(posedge tmr_clk_i) begin
      start_sync_q <= {start_sync_q[1:0], start_tgl_i};
   end

   // Count out programming time, then answer with a toggle
   always_ff @(posedge tmr_clk_i) begin
      if (start_sync_q[2] != start_sync_q[1]) begin
         start_seen_q <= start_sync_q[1];
         busy_q       <= 1'b1;
         count_q      <= 16'h0000;
      end else if (busy_q) begin
         if (count_q == 16'(TICKS - 1)) begin
            busy_q     <= 1'b0;
            done_tgl_o <= start_seen_q;
         end else begin
            count_q <= count_q + 16'h0001;
         end
      end
   end
endmodule

// ---- sim/eeprom_ctrl_props.sv ----
// Port checker for the EEPROM data access controller
`timescale 1ns/1ps
module eeprom_ctrl_props (
   input wire logic       MCLK_I,
   input wire logic       RST_B_I,
   input wire logic       CLK_EN_I,
   input wire logic       SFR_RD_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [7:0] SFR_RDATA_O,
   input wire logic       BANK_SELECT_O,
   input wire logic       EEPROM_IRQ_FLAG_O,
   input wire logic       MULTI_IRQ_FLAG_O,
   input wire logic       IRQ_VECTOR_O,
   input wire logic       GLOBAL_IRQ_ENABLE_I,
   input wire logic       MULTI_IRQ_ENABLE_I,
   input wire logic       STACK_FULL_I,
   input wire logic       MULTI_SERVICE_I,
   input wire logic       EEPROM_IRQ_FLAG_CLR_I,
   input wire logic       BUSY_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);
   ////////////////////////////////////////////////////////////////////////
   // Read strobe taken, and the cycle steps
   wire rd_any = SFR_RD_I && CLK_EN_I;
   sequence cyc_start; $rose(BUSY_O); endsequence
   // Bound covers the slow write timer plus synchroniser
   sequence cyc_end; ##[1:600] !BUSY_O; endsequence
   ////////////////////////////////////////////////////////////////////////
   a_addr_top_zero: assert property ($past(rd_any && SFR_ADDR_I == 8'h00)
      |-> SFR_RDATA_O[7:6] == 2'h0) else $error("address top bits set");
   a_ctrl_top_zero: assert property ($past(rd_any && SFR_ADDR_I == 8'h40)
      |-> SFR_RDATA_O[7:4] == 4'h0) else $error("control top nibble set");
   a_ctrl_bank_hide: assert property ($past(rd_any && SFR_ADDR_I == 8'h40
      && !BANK_SELECT_O) |-> SFR_RDATA_O == 8'h00) else $error("bank 0 leak");
   a_reset_clears: assert property (disable iff (1'b0)
      !RST_B_I && CLK_EN_I |=> !BANK_SELECT_O && !BUSY_O && !EEPROM_IRQ_FLAG_O)
      else $error("reset state wrong");
   a_cycle_ends: assert property (cyc_start |-> cyc_end)
      else $error("cycle never ends");
   a_flags_pair: assert property ($rose(EEPROM_IRQ_FLAG_O)
      |-> MULTI_IRQ_FLAG_O) else $error("multi flag missing");
   a_vector_gated: assert property (IRQ_VECTOR_O |-> $past(MULTI_IRQ_FLAG_O
      && EEPROM_IRQ_FLAG_O && GLOBAL_IRQ_ENABLE_I && MULTI_IRQ_ENABLE_I
      && !STACK_FULL_I)) else $error("vector without enables");
   a_service_clears: assert property (MULTI_SERVICE_I && CLK_EN_I
      |=> !MULTI_IRQ_FLAG_O || $rose(EEPROM_IRQ_FLAG_O))
      else $error("multi flag kept");
   a_service_keeps: assert property (MULTI_SERVICE_I && CLK_EN_I &&
      EEPROM_IRQ_FLAG_O && !EEPROM_IRQ_FLAG_CLR_I |=> EEPROM_IRQ_FLAG_O)
      else $error("eeprom flag lost");
endmodule
bind eeprom_data_access_ctrl eeprom_ctrl_props props (.*);

// ---- sim/cpu_core_model.sv ----
// Behavioural core driving the special function register bus
`timescale 1ns/1ps
module cpu_core_model (
   input  wire logic  clk_i,
   output logic       wr_o,
   output logic       rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic       bank_wr_o,
   output logic       bank_o,
   output logic       gie_o
);
   initial begin
      {wr_o, rd_o, bank_wr_o, bank_o, gie_o} = 5'h01;
      addr_o = 8'hA5;
      wdata_o = 8'h5A;
   end
   // One instruction; a released bus shows inverted junk, not old data
   task automatic cyc(logic w, logic [7:0] a, logic [7:0] d);
      @(negedge clk_i);
      wr_o = w;
      rd_o = !w;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      {wr_o, rd_o} = 2'h0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // Bank select update
   task automatic bank(logic b);
      @(negedge clk_i);
      bank_wr_o = 1'b1;
      bank_o = b;
      @(negedge clk_i);
      bank_wr_o = 1'b0;
      bank_o = !b;
   endtask
   // Read: permit, address, go; go bits never share one write
   task automatic fetch(logic [7:0] a);
      cyc(1'b1, 8'h40, 8'h02);
      cyc(1'b1, 8'h00, a);
      cyc(1'b1, 8'h40, 8'h03);
      repeat (3) @(negedge clk_i);
   endtask
   // Write with interrupts masked, go right after permit, then disarm
   task automatic prog_byte(logic [7:0] a, logic [7:0] d);
      gie_o = 1'b0;
      cyc(1'b1, 8'h00, a);
      cyc(1'b1, 8'h01, d);
      cyc(1'b1, 8'h40, 8'h08);
      cyc(1'b1, 8'h40, 8'h0C);
      gie_o = 1'b1;
      cyc(1'b1, 8'h40, 8'h00);
   endtask
endmodule

// ---- sim/eeprom_data_access_ctrl_test.sv ----
// Self-checking bench for the EEPROM data access controller
`timescale 1ns/1ps
module eeprom_data_access_ctrl_test;
   logic       clk = 1'b0, rst_b = 1'b0, tmr = 1'b0, m_en = 1'b0;
   logic       ee_wr = 1'b0, stk = 1'b0, svc = 1'b0, fclr = 1'b0;
   logic       cen = 1'b1, ee_en = 1'b1;
   logic       wr, rd_s, bwr, bwd, gie, bsel, ee_f, m_f, vec, busy;
   logic       rd_pend = 1'b0;
   logic [7:0] addr, wd, rdata, a_x, d_x;
   logic [7:0] exp_q[$];
   int         n_errors = 0, checks = 0, cyc = 0;
   initial forever #25 clk = ~clk;
   // Timer oscillator, phase unrelated to the system clock
   initial #7 forever #500 tmr = ~tmr;
   eeprom_data_access_ctrl #(.PROG_TICKS(4)) dut (.MCLK_I(clk),
      .RST_B_I(rst_b), .CLK_EN_I(cen), .TMR_CLK_I(tmr), .SFR_WR_I(wr),
      .SFR_RD_I(rd_s), .SFR_ADDR_I(addr), .SFR_WDATA_I(wd), .BANK_WR_I(bwr),
      .BANK_WDATA_I(bwd), .GLOBAL_IRQ_ENABLE_I(gie), .MULTI_IRQ_ENABLE_I(m_en),
      .STACK_FULL_I(stk), .MULTI_SERVICE_I(svc), .EEPROM_IRQ_ENABLE_WR_I(ee_wr),
      .EEPROM_IRQ_ENABLE_I(ee_en), .EEPROM_IRQ_FLAG_CLR_I(fclr),
      .SFR_RDATA_O(rdata), .BANK_SELECT_O(bsel), .EEPROM_IRQ_FLAG_O(ee_f),
      .MULTI_IRQ_FLAG_O(m_f), .IRQ_VECTOR_O(vec), .BUSY_O(busy));
   cpu_core_model core (.clk_i(clk), .wr_o(wr), .rd_o(rd_s), .addr_o(addr),
      .wdata_o(wd), .bank_wr_o(bwr), .bank_o(bwd), .gie_o(gie));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(string nm, logic e, logic g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %b got %b", nm, e, g);
      end
   endtask
   // Note the expected byte, then issue the read
   task automatic rd(logic [7:0] a, logic [7:0] e);
      exp_q.push_back(e);
      core.cyc(1'b0, a, 8'h00);
   endtask
   task automatic summarize();
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Read data stands one cycle after the strobe; hang guard last
   always @(posedge clk) rd_pend <= rd_s;
   always @(negedge clk) begin
      cyc++;
      if (rd_pend)
         chk("read data", exp_q.pop_front(), rdata);
      if (cyc > 4000) begin
         n_errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h5B044413));
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      m_en = 1'b1;
      ee_wr = 1'b1;
      @(negedge clk);
      ee_wr = 1'b0;
      chk_flag("bank select", 1'b0, bsel);
      rd(8'h40, 8'h00);
      core.cyc(1'b1, 8'h40, 8'h0A);
      core.bank(1'b1);
      rd(8'h40, 8'h00);
      core.cyc(1'b1, 8'h00, 8'hFF);
      rd(8'h00, 8'h3F);
      d_x = 8'($urandom);
      core.cyc(1'b1, 8'h01, d_x);
      rd(8'h01, d_x);
      // Clock enable low: a data write must leave no trace
      cen = 1'b0;
      core.cyc(1'b1, 8'h01, ~d_x);
      cen = 1'b1;
      rd(8'h01, d_x);
      core.cyc(1'b1, 8'h40, 8'h04);
      rd(8'h40, 8'h00);
      core.cyc(1'b1, 8'h40, 8'h01);
      rd(8'h40, 8'h00);
      rd(8'h01, d_x);
      // Pass 0 vectors, pass 1 has a full stack, pass 2 no enable
      for (int i = 0; i < 3; i++) begin
         a_x = (i == 0) ? 8'h3F : 8'($urandom_range(62));
         d_x = 8'($urandom);
         stk = (i == 1);
         ee_en = (i != 2);
         ee_wr = 1'b1;
         @(negedge clk);
         ee_wr = 1'b0;
         core.prog_byte(a_x, d_x);
         rd(8'h40, 8'h04);
         chk_flag("busy", 1'b1, busy);
         for (int k = 0; k < 400 && ee_f !== 1'b1; k++)
            @(negedge clk);
         chk_flag("multi flag", 1'b1, m_f);
         @(negedge clk);
         chk_flag("vector", i == 0, vec);
         chk_flag("busy", 1'b0, busy);
         svc = 1'b1;
         @(negedge clk);
         svc = 1'b0;
         @(negedge clk);
         chk_flag("multi flag", 1'b0, m_f);
         chk_flag("eeprom flag", 1'b1, ee_f);
         fclr = 1'b1;
         @(negedge clk);
         fclr = 1'b0;
         rd(8'h40, 8'h00);
         core.fetch(a_x);
         rd(8'h40, 8'h02);
         rd(8'h01, d_x);
         chk_flag("eeprom flag", 1'b0, ee_f);
         core.cyc(1'b1, 8'h40, 8'h00);
      end
      // Mid-run reset must drop both permits and the bank select
      core.cyc(1'b1, 8'h40, 8'h0A);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk_flag("bank select", 1'b0, bsel);
      core.bank(1'b1);
      rd(8'h40, 8'h00);
      summarize();
   end
endmodule
